// [hdl/qu_chan_ctrl.sv]
`timescale 1ns/1ps
// Overview of operation
// - Modem-control bit 0 drives terminal-ready low; in loopback it feeds state bit 5.
// - Modem-control bits 7..5 are writable only with enhanced enable set.
// - State bits 7..4 show inverted modem inputs, or control bits 3,2,0,1 in loopback.
// - Change bits latch edges of CD, DSR, CTS, falling RI; cleared on read.
// - Interrupt enable gates seven sources; all disabled after reset.
// - Interrupt-enable bit 4 selects sleep mode; reset value is off.
// - Interrupt-enable bits 7..4 are writable only with enhanced enable set.
// - Re-enabling transmit interrupt raises a fresh one when free space is at or above the transmit trigger.
// - Source register mirrors FIFO enable in bits 7..6; bit 0 low when pending.
// - Highest-priority source coded in bits 5..0 per the priority table.
// - Bit 4 flags special char; bit 5 flags CTS/RTS deassertion.
// - CTS flow control stops transmission while clear-to-send input is high.
// - Auto RTS goes high at halt level and low at resume level.
// - Special detect compares received chars to second stop char; still stored.
// - Divisor bytes form a 16-bit divisor, writable only outside sleep.
// - Flow thresholds: halt in bits 3..0, resume in 7..4, steps of four.
// - Threshold and trigger registers writable only with enhanced and bit 6 set.
// - Trigger register: receive in 7..4, transmit in 3..0, level over four.
// - A zero trigger field falls back to the FIFO setup trigger.
// - Ready summary: receive bits above trigger or timeout, transmit bits at trigger.
// - Summary readable at address 7 with channel selected, bit 2 set, no loopback.
// - Modem-control bit 4 selects loopback of control lines and serial data.
// - FIFO setup receive trigger codes select 8, 16, 56 or 60 characters.
module qu_chan_ctrl
  import qu_pkg::*;
#(
  parameter int CHAN = 0
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic cs_b,
  input wire logic [3:0] any_cs_b,
  input wire logic [2:0] addr,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic [3:0] peer_rx_rdy,
  input wire logic [3:0] peer_tx_rdy,
  output logic rx_rdy,
  output logic tx_rdy,
  input wire qu_modem_in_t modem_in,
  output logic dtr_b,
  output logic rts_b,
  output logic op_b,
  input wire logic rx_pin,
  output logic rx_serial,
  input wire logic tx_serial,
  output logic tx_pin,
  input wire qu_fifo_stat_t fifo_stat,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic tx_ready_in,
  output logic tx_char_valid,
  output logic [7:0] tx_char,
  output logic tx_ready_out,
  input wire logic tx_push,
  input wire logic [7:0] tx_push_data,
  output logic tx_halt,
  output logic sleep_mode,
  output logic [15:0] divisor,
  output logic irq
);
  logic [7:0] mcr_r, mcr_nxt, ier_r, ier_nxt, efr_r, efr_nxt, lcr_r, lcr_nxt;
  logic [7:0] dll_r, dll_nxt, dlm_r, dlm_nxt, tcr_r, tcr_nxt, tlr_r, tlr_nxt;
  logic [7:0] fcr_r, fcr_nxt, second_stop_char_r, second_stop_char_nxt;
  logic [3:0] delta_r, delta_nxt, lines_r, lines_nxt;
  logic [3:0] m1_r, m2_r;
  logic rx_s1_r, rx_s2_r;
  logic auto_rts_r, auto_rts_nxt, thr_evt_r, thr_evt_nxt, spc_r, spc_nxt;
  logic flow_r, flow_nxt, cts_d_r, cts_d_nxt, rts_d_r, rts_d_nxt;
  logic ext, wr, rd, frdy_sel, loop;
  logic [3:0] lines_now;
  logic [6:0] rx_trig, tx_trig;
  logic [5:0] src_id;
  logic pend;
  logic [7:0] fifo_out;
  logic fifo_out_valid;

  function automatic logic [6:0] lvl4(input logic [3:0] f);
    lvl4 = {1'b0, f, 2'b00};
  endfunction

  assign ext = lcr_r == QU_LCR_EXT;
  assign wr = wr_stb && !cs_b;
  assign rd = rd_stb && !cs_b;
  assign loop = mcr_r[QU_MCR_LOOP];
  assign frdy_sel = (any_cs_b != 4'hF) && mcr_r[QU_MCR_FRDY] && !loop;
  assign sleep_mode = ier_r[QU_IER_SLP];
  assign divisor = {dlm_r, dll_r};

  // Loopback: control bits 3,2,0,1 stand in for CD, RI, DSR, CTS.
  assign lines_now = loop ? {mcr_r[QU_MCR_OP], mcr_r[QU_MCR_FRDY], mcr_r[QU_MCR_DTR],
                             mcr_r[QU_MCR_RTS]} : ~m2_r;
  assign dtr_b = loop ? 1'b1 : !mcr_r[QU_MCR_DTR];
  assign op_b = !mcr_r[QU_MCR_OP];
  assign rts_b = loop ? 1'b1 :
    (efr_r[QU_EFR_ARTS] ? auto_rts_r : !mcr_r[QU_MCR_RTS]);
  assign rx_serial = loop ? tx_serial : rx_s2_r;
  assign tx_pin = loop ? 1'b1 : tx_serial;
  assign tx_halt = efr_r[QU_EFR_ACTS] && !lines_now[0];

  // Trigger levels, with setup-register fallback for zero fields.
  always_comb begin
    rx_trig = lvl4(tlr_r[7:4]);
    tx_trig = lvl4(tlr_r[3:0]);
    if (tlr_r[7:4] == 4'h0) begin
      case (fcr_r[7:6])
        2'b00: rx_trig = QU_RXT0;
        2'b01: rx_trig = QU_RXT1;
        2'b10: rx_trig = QU_RXT2;
        default: rx_trig = QU_RXT3;
      endcase
    end
    if (tlr_r[3:0] == 4'h0) begin
      case (fcr_r[5:4])
        2'b00: tx_trig = QU_TXT0;
        2'b01: tx_trig = QU_TXT1;
        2'b10: tx_trig = QU_TXT2;
        default: tx_trig = QU_TXT3;
      endcase
    end
  end
  assign rx_rdy = (fifo_stat.rx_level > rx_trig) || fifo_stat.rx_timeout;
  assign tx_rdy = fifo_stat.tx_free >= tx_trig;

  // Priority encoder of pending sources.
  always_comb begin
    pend = 1'b1;
    src_id = QU_ID_MS;
    if (ier_r[QU_IER_LS] && fifo_stat.ls_error) begin
      src_id = QU_ID_LS;
    end else if (ier_r[QU_IER_RX] && fifo_stat.rx_timeout) begin
      src_id = QU_ID_TO;
    end else if (ier_r[QU_IER_RX] && rx_rdy) begin
      src_id = QU_ID_RX;
    end else if (ier_r[QU_IER_TX] && thr_evt_r) begin
      src_id = QU_ID_TX;
    end else if (ier_r[QU_IER_MS] && delta_r != 4'h0) begin
      src_id = QU_ID_MS;
    end else if (ier_r[QU_IER_XOFF] && spc_r) begin
      src_id = QU_ID_XOFF;
    end else if ((ier_r[QU_IER_RTSC] || ier_r[QU_IER_CTSC]) && flow_r) begin
      src_id = QU_ID_FLOW;
    end else begin
      pend = 1'b0;
    end
  end
  assign irq = pend;

  always_comb begin
    rdata = QU_RST8;
    if (rd) begin
      case (addr)
        QU_A_ISR: rdata = ext ? efr_r : {{2{fcr_r[0]}}, src_id[5:1], !pend};
        QU_A_LCR: rdata = lcr_r;
        QU_A_MCR: rdata = mcr_r;
        QU_A_IER: rdata = (lcr_r[7] && !ext) ? dlm_r : ier_r;
        QU_A_DATA: rdata = lcr_r[7] ? dll_r : 8'h00;
        QU_A_MSR: rdata = ext ? 8'h00 : (mcr_r[QU_MCR_TLEN] ? tcr_r : {lines_r, delta_r});
        default: begin
          if (frdy_sel) begin
            rdata = {peer_rx_rdy, peer_tx_rdy};
          end else if (ext) begin
            rdata = second_stop_char_r;
          end else begin
            rdata = mcr_r[QU_MCR_TLEN] ? tlr_r : 8'h00;
          end
        end
      endcase
    end
  end

  always_comb begin
    mcr_nxt = mcr_r;
    ier_nxt = ier_r;
    efr_nxt = efr_r;
    lcr_nxt = lcr_r;
    dll_nxt = dll_r;
    dlm_nxt = dlm_r;
    tcr_nxt = tcr_r;
    tlr_nxt = tlr_r;
    fcr_nxt = fcr_r;
    second_stop_char_nxt = second_stop_char_r;
    thr_evt_nxt = thr_evt_r;
    if (wr) begin
      case (addr)
        QU_A_LCR: lcr_nxt = wdata;
        QU_A_ISR: begin
          if (ext) begin
            efr_nxt = wdata;
          end else if (efr_r[QU_EFR_ENH]) begin
            fcr_nxt = wdata;
          end else begin
            fcr_nxt = {wdata[7:6], fcr_r[5:4], wdata[3:0]};
          end
        end
        QU_A_MCR: begin
          if (efr_r[QU_EFR_ENH]) begin
            mcr_nxt = wdata;
          end else begin
            mcr_nxt = (mcr_r & QU_MCR_EMASK) | (wdata & ~QU_MCR_EMASK);
          end
        end
        QU_A_IER: begin
          if (lcr_r[7] && !ext) begin
            if (!ier_r[QU_IER_SLP]) dlm_nxt = wdata;
          end else if (!ext) begin
            if (efr_r[QU_EFR_ENH]) begin
              ier_nxt = wdata;
            end else begin
              ier_nxt = (ier_r & QU_HI_MASK) | (wdata & ~QU_HI_MASK);
            end
          end
        end
        QU_A_DATA: begin
          if (lcr_r[7] && !ier_r[QU_IER_SLP]) dll_nxt = wdata;
        end
        QU_A_MSR: begin
          if (efr_r[QU_EFR_ENH] && mcr_r[QU_MCR_TLEN]) tcr_nxt = wdata;
        end
        default: begin
          if (ext) begin
            second_stop_char_nxt = wdata;
          end else if (efr_r[QU_EFR_ENH] && mcr_r[QU_MCR_TLEN]) begin
            tlr_nxt = wdata;
          end
        end
      endcase
    end
    if ((rd && addr == QU_A_ISR && !ext && src_id == QU_ID_TX) || tx_push) begin
      thr_evt_nxt = 1'b0;
    end
    // A re-enable in the same cycle as a clear still raises the event.
    if (wr && addr == QU_A_IER && !lcr_r[7] && !ext && wdata[QU_IER_TX] &&
        !ier_r[QU_IER_TX] && tx_rdy) begin
      thr_evt_nxt = 1'b1;
    end
    if (fcr_r[2]) fcr_nxt[2] = 1'b0;
    if (fcr_r[1]) fcr_nxt[1] = 1'b0;
  end

  // Modem change detection, flow control and special character.
  always_comb begin
    lines_nxt = lines_now;
    delta_nxt = delta_r;
    if (rd && addr == QU_A_MSR && !ext && !mcr_r[QU_MCR_TLEN]) begin
      delta_nxt = 4'h0;
    end
    delta_nxt[3] = delta_nxt[3] | (lines_now[3] ^ lines_r[3]);
    delta_nxt[2] = delta_nxt[2] | (!lines_now[2] && lines_r[2]);
    delta_nxt[1] = delta_nxt[1] | (lines_now[1] ^ lines_r[1]);
    delta_nxt[0] = delta_nxt[0] | (lines_now[0] ^ lines_r[0]);
    auto_rts_nxt = auto_rts_r;
    if (fifo_stat.rx_level >= lvl4(tcr_r[3:0])) begin
      auto_rts_nxt = 1'b1;
    end else if (fifo_stat.rx_level <= lvl4(tcr_r[7:4])) begin
      auto_rts_nxt = 1'b0;
    end
    cts_d_nxt = lines_now[0];
    rts_d_nxt = rts_b;
    flow_nxt = flow_r;
    spc_nxt = spc_r;
    if (rd && addr == QU_A_ISR && !ext) begin
      flow_nxt = 1'b0;
      spc_nxt = 1'b0;
    end
    if ((ier_r[QU_IER_CTSC] && cts_d_r && !lines_now[0]) ||
        (ier_r[QU_IER_RTSC] && !rts_d_r && rts_b)) begin
      flow_nxt = 1'b1;
    end
    if (efr_r[QU_EFR_SPC] && rx_char_valid && rx_char == second_stop_char_r) begin
      spc_nxt = 1'b1;
    end
  end

  qu_fifo #(.WIDTH(8), .DEPTH(8)) u_txbuf (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .in_valid(tx_push),
    .in_ready(tx_ready_out),
    .in_data(tx_push_data),
    .out_valid(fifo_out_valid),
    .out_ready(tx_ready_in && !tx_halt),
    .out_data(fifo_out)
  );
  assign tx_char_valid = fifo_out_valid && !tx_halt;
  assign tx_char = fifo_out;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mcr_r <= QU_RST8;
      ier_r <= QU_RST8;
      efr_r <= QU_RST8;
      lcr_r <= QU_RST8;
      dll_r <= QU_RST8;
      dlm_r <= QU_RST8;
      tcr_r <= QU_RST8;
      tlr_r <= QU_RST8;
      fcr_r <= QU_RST8;
      second_stop_char_r <= QU_RST8;
      delta_r <= 4'h0;
      lines_r <= 4'h0;
      m1_r <= 4'hF;
      m2_r <= 4'hF;
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      auto_rts_r <= 1'b0;
      thr_evt_r <= 1'b0;
      spc_r <= 1'b0;
      flow_r <= 1'b0;
      cts_d_r <= 1'b0;
      rts_d_r <= 1'b1;
    end else if (clk_en) begin
      mcr_r <= mcr_nxt;
      ier_r <= ier_nxt;
      efr_r <= efr_nxt;
      lcr_r <= lcr_nxt;
      dll_r <= dll_nxt;
      dlm_r <= dlm_nxt;
      tcr_r <= tcr_nxt;
      tlr_r <= tlr_nxt;
      fcr_r <= fcr_nxt;
      second_stop_char_r <= second_stop_char_nxt;
      delta_r <= delta_nxt;
      lines_r <= lines_nxt;
      m1_r <= modem_in;
      m2_r <= m1_r;
      rx_s1_r <= rx_pin;
      rx_s2_r <= rx_s1_r;
      auto_rts_r <= auto_rts_nxt;
      thr_evt_r <= thr_evt_nxt;
      spc_r <= spc_nxt;
      flow_r <= flow_nxt;
      cts_d_r <= cts_d_nxt;
      rts_d_r <= rts_d_nxt;
    end
  end

  mcr_guard_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && wr && addr == QU_A_MCR && !efr_r[QU_EFR_ENH] && !ext
    |=> mcr_r[7:5] == $past(mcr_r[7:5])) else $error("modem control high bits changed");
  ier_guard_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && wr && addr == QU_A_IER && !lcr_r[7] && !efr_r[QU_EFR_ENH]
    |=> ier_r[7:4] == $past(ier_r[7:4])) else $error("enable high bits changed");
  div_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sleep_mode |=> divisor == $past(divisor)) else $error("divisor written in sleep");
  loop_map_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && loop && $stable(mcr_r)
    |=> lines_r == {$past(mcr_r[3]), $past(mcr_r[2]), $past(mcr_r[0]), $past(mcr_r[1])})
    else $error("loopback mapping wrong");
  dtr_out_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !loop |-> dtr_b == !mcr_r[QU_MCR_DTR]) else $error("terminal ready level wrong");
  cts_halt_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    efr_r[QU_EFR_ACTS] && !loop && m2_r[0] |-> !tx_char_valid)
    else $error("sent while clear-to-send high");
  isr_none_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ier_r == 8'h00 && rd && addr == QU_A_ISR && !ext |-> rdata[5:0] == 6'h01)
    else $error("pending shown with sources off");
  ri_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && !delta_r[2] && lines_r[2] && !lines_now[2] && !loop |=> delta_r[2])
    else $error("ring edge missed");
  tlr_guard_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(efr_r[QU_EFR_ENH] && mcr_r[QU_MCR_TLEN]) |=> tlr_r == $past(tlr_r))
    else $error("trigger register written while locked");
endmodule

// [hdl/qu_fifo.sv]
`timescale 1ns/1ps
module qu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;
  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = in_data;
      wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (clk_en) begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// [shared/qu_pkg.sv]
package qu_pkg;
  localparam logic [2:0] QU_A_DATA = 3'h0;
  localparam logic [2:0] QU_A_IER = 3'h1;
  localparam logic [2:0] QU_A_ISR = 3'h2;
  localparam logic [2:0] QU_A_LCR = 3'h3;
  localparam logic [2:0] QU_A_MCR = 3'h4;
  localparam logic [2:0] QU_A_MSR = 3'h6;
  localparam logic [2:0] QU_A_SPR = 3'h7;
  localparam logic [2:0] QU_A_FRDY = 3'h7;
  localparam logic [2:0] QU_A_TCR = 3'h6;
  localparam logic [2:0] QU_A_TLR = 3'h7;
  localparam logic [2:0] QU_A_SECOND_STOP_CHAR = 3'h7;
  localparam logic [7:0] QU_LCR_EXT = 8'h00BF;
  localparam int QU_MCR_DTR = 0;
  localparam int QU_MCR_RTS = 1;
  localparam int QU_MCR_FRDY = 2;
  localparam int QU_MCR_OP = 3;
  localparam int QU_MCR_LOOP = 4;
  localparam int QU_MCR_TLEN = 6;
  localparam int QU_EFR_ENH = 4;
  localparam int QU_EFR_SPC = 5;
  localparam int QU_EFR_ARTS = 6;
  localparam int QU_EFR_ACTS = 7;
  localparam int QU_IER_RX = 0;
  localparam int QU_IER_TX = 1;
  localparam int QU_IER_LS = 2;
  localparam int QU_IER_MS = 3;
  localparam int QU_IER_SLP = 4;
  localparam int QU_IER_XOFF = 5;
  localparam int QU_IER_RTSC = 6;
  localparam int QU_IER_CTSC = 7;
  localparam logic [7:0] QU_RST8 = 8'h0000;
  localparam logic [7:0] QU_HI_MASK = 8'h00F0;
  localparam logic [7:0] QU_MCR_EMASK = 8'h00E0;
  localparam logic [5:0] QU_ID_LS = 6'h06;
  localparam logic [5:0] QU_ID_TO = 6'h0C;
  localparam logic [5:0] QU_ID_RX = 6'h04;
  localparam logic [5:0] QU_ID_TX = 6'h02;
  localparam logic [5:0] QU_ID_MS = 6'h00;
  localparam logic [5:0] QU_ID_XOFF = 6'h10;
  localparam logic [5:0] QU_ID_FLOW = 6'h20;
  localparam logic [6:0] QU_RXT0 = 7'd8;
  localparam logic [6:0] QU_RXT1 = 7'd16;
  localparam logic [6:0] QU_RXT2 = 7'd56;
  localparam logic [6:0] QU_RXT3 = 7'd60;
  localparam logic [6:0] QU_TXT0 = 7'd8;
  localparam logic [6:0] QU_TXT1 = 7'd16;
  localparam logic [6:0] QU_TXT2 = 7'd32;
  localparam logic [6:0] QU_TXT3 = 7'd56;
  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } qu_modem_in_t;
  typedef struct packed {
    logic [6:0] rx_level;
    logic [6:0] tx_free;
    logic rx_timeout;
    logic ls_error;
  } qu_fifo_stat_t;
  typedef enum logic [1:0] {QU_IDLE, QU_LOAD, QU_SEND} qu_tx_state_t;
endpackage

// [test/qu_modem_peer.sv]
`timescale 1ns/1ps
module qu_modem_peer
  import qu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic dtr_b,
  input wire logic rts_b,
  input wire logic tx_pin,
  output qu_modem_in_t modem_in,
  output logic rx_pin
);
  logic may_send;
  // The remote end only sends while both of our ready lines are active.
  // It never sends in this bench, so its data line rests at the mark level.
  assign may_send = ~rts_b & ~dtr_b & tx_pin;
  initial begin
    modem_in = 4'hf;
    rx_pin = 1'b1;
  end
  // All four lines are active low; a high clear-to-send line asks the device to stop.
  task automatic set_lines(input logic [3:0] lines);
    @(negedge sys_clk);
    modem_in = lines;
  endtask
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import qu_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cs_b = 1'b1;
  logic [2:0] addr = 3'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [3:0] peer_rx_rdy = 4'ha;
  logic [3:0] peer_tx_rdy = 4'h5;
  logic tx_serial = 1'b1;
  logic rx_char_valid = 1'b0;
  logic [7:0] rx_char = 8'h00;
  logic tx_ready_in = 1'b0;
  logic tx_push = 1'b0;
  logic [7:0] tx_push_data = 8'h00;
  qu_fifo_stat_t fifo_stat = '{7'h00, 7'h40, 1'b0, 1'b0};
  qu_modem_in_t modem_in;
  logic [7:0] rdata;
  logic [7:0] tx_char;
  logic [15:0] divisor;
  logic rx_rdy, tx_rdy, dtr_b, rts_b, op_b, rx_pin, rx_serial, tx_pin;
  logic tx_char_valid, tx_ready_out, tx_halt, sleep_mode, irq;
  int err_count = 0;
  int n_checks = 0;
  logic [6:0] trig [4] = '{7'h08, 7'h10, 7'h38, 7'h3c};

  always #20 sys_clk = ~sys_clk;

  qu_chan_ctrl #(.CHAN(0)) qu_chan_ctrl_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .cs_b(cs_b),
    .any_cs_b({3'b111, cs_b}), .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .wdata(wdata), .rdata(rdata), .peer_rx_rdy(peer_rx_rdy), .peer_tx_rdy(peer_tx_rdy),
    .rx_rdy(rx_rdy), .tx_rdy(tx_rdy), .modem_in(modem_in), .dtr_b(dtr_b),
    .rts_b(rts_b), .op_b(op_b), .rx_pin(rx_pin), .rx_serial(rx_serial),
    .tx_serial(tx_serial), .tx_pin(tx_pin), .fifo_stat(fifo_stat),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char), .tx_ready_in(tx_ready_in),
    .tx_char_valid(tx_char_valid), .tx_char(tx_char), .tx_ready_out(tx_ready_out),
    .tx_push(tx_push), .tx_push_data(tx_push_data), .tx_halt(tx_halt),
    .sleep_mode(sleep_mode), .divisor(divisor), .irq(irq)
  );

  qu_modem_peer qu_modem_peer_i (
    .sys_clk(sys_clk), .dtr_b(dtr_b), .rts_b(rts_b), .tx_pin(tx_pin),
    .modem_in(modem_in), .rx_pin(rx_pin)
  );

  task automatic complete_run;
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    cs_b = 1'b0;
    addr = a;
    wdata = d;
    wr_stb = 1'b1;
    @(negedge sys_clk);
    wr_stb = 1'b0;
    cs_b = 1'b1;
    @(negedge sys_clk);
  endtask

  // Reads hold the strobe for exactly one edge so side effects happen once.
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
    cs_b = 1'b0;
    addr = a;
    rd_stb = 1'b1;
    #19;
    chk({8'h00, rdata & m}, {8'h00, exp & m});
    @(negedge sys_clk);
    rd_stb = 1'b0;
    cs_b = 1'b1;
    @(negedge sys_clk);
  endtask

  task automatic lines(input logic [3:0] v);
    qu_modem_peer_i.set_lines(v);
    cyc(4);
  endtask

  task automatic level(input logic [6:0] rx, input logic [6:0] tx);
    fifo_stat.rx_level = rx;
    fifo_stat.tx_free = tx;
    cyc(2);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    complete_run();
  end

  initial begin
    int k;
    cyc(3);
    rst_b = 1'b1;
    cyc(1);
    rd(QU_A_IER, 8'h00);
    chk(16'(sleep_mode), 16'h0000);
    chk({13'h0000, dtr_b, rts_b, irq}, 16'h0006);
    rd(QU_A_ISR, 8'h01);
    wr(QU_A_MCR, 8'h01);
    chk(16'(dtr_b), 16'h0000);
    wr(QU_A_MCR, 8'he0);
    chk(16'(dtr_b), 16'h0001);
    rd(QU_A_MCR, 8'h00);
    wr(QU_A_IER, 8'hf0);
    rd(QU_A_IER, 8'h00);
    // Fill the transmit buffer while the transmitter stalls, then drain it.
    for (int i = 0; i < 9; i++) begin
      tx_push = 1'b1;
      tx_push_data = 8'ha0 + 8'(i);
      cyc(1);
    end
    tx_push = 1'b0;
    chk(16'(tx_ready_out), 16'h0000);
    for (int i = 0; i < 8; i++) begin
      k = 0;
      while (tx_char_valid !== 1'b1 && k < 20) begin
        cyc(1);
        k++;
      end
      if (k == 20) begin
        err_count++;
        complete_run();
      end
      chk({8'h00, tx_char}, {8'h00, 8'ha0 + 8'(i)});
      tx_ready_in = 1'b1;
      cyc(1);
      tx_ready_in = 1'b0;
      cyc(1);
    end
    cyc(2);
    chk({14'h0000, tx_char_valid, tx_ready_out}, 16'h0001);
    rd(QU_A_MSR, 8'h00, 8'h00);
    rd(QU_A_MSR, 8'h00);
    lines(4'b1110);
    rd(QU_A_MSR, 8'h11);
    rd(QU_A_MSR, 8'h10);
    lines(4'b1010);
    rd(QU_A_MSR, 8'h50);
    lines(4'b1110);
    rd(QU_A_MSR, 8'h14);
    rd(QU_A_MSR, 8'h10);
    tx_serial = 1'b0;
    wr(QU_A_MCR, 8'h1b);
    rd(QU_A_MSR, 8'h00, 8'h00);
    rd(QU_A_MSR, 8'hb0);
    cyc(3);
    chk({14'h0000, tx_pin, rx_serial}, 16'h0002);
    tx_serial = 1'b1;
    wr(QU_A_MCR, 8'h00);
    rd(QU_A_MSR, 8'h00, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(QU_A_ISR, {2'(c), 6'h01});
      level(trig[c], 7'h08);
      chk({14'h0000, rx_rdy, tx_rdy}, 16'h0001);
      level(trig[c] + 7'h01, 7'h07);
      chk({14'h0000, rx_rdy, tx_rdy}, 16'h0002);
    end
    wr(QU_A_ISR, 8'h01);
    fifo_stat = '{7'h14, 7'h00, 1'b0, 1'b1};
    wr(QU_A_IER, 8'h05);
    rd(QU_A_ISR, 8'hc6);
    fifo_stat.ls_error = 1'b0;
    fifo_stat.rx_timeout = 1'b1;
    rd(QU_A_ISR, 8'hcc);
    fifo_stat.rx_timeout = 1'b0;
    rd(QU_A_ISR, 8'hc4);
    chk(16'(irq), 16'h0001);
    level(7'h00, 7'h40);
    rd(QU_A_ISR, 8'hc1);
    wr(QU_A_IER, 8'h02);
    rd(QU_A_ISR, 8'hc2);
    rd(QU_A_ISR, 8'hc1);
    wr(QU_A_IER, 8'h00);
    wr(QU_A_IER, 8'h02);
    rd(QU_A_ISR, 8'hc2);
    wr(QU_A_IER, 8'h08);
    lines(4'b0110);
    rd(QU_A_ISR, 8'hc0);
    rd(QU_A_MSR, 8'h98);
    rd(QU_A_ISR, 8'hc1);
    wr(QU_A_IER, 8'h00);
    wr(QU_A_LCR, QU_LCR_EXT);
    wr(QU_A_ISR, 8'h10);
    wr(QU_A_SECOND_STOP_CHAR, 8'h13);
    wr(QU_A_LCR, 8'h00);
    wr(QU_A_IER, 8'h10);
    chk(16'(sleep_mode), 16'h0001);
    wr(QU_A_LCR, 8'h80);
    wr(QU_A_DATA, 8'h34);
    chk(divisor, 16'h0000);
    wr(QU_A_LCR, 8'h00);
    wr(QU_A_IER, 8'h00);
    wr(QU_A_LCR, 8'h80);
    wr(QU_A_DATA, 8'h34);
    wr(QU_A_IER, 8'h12);
    chk(divisor, 16'h1234);
    wr(QU_A_LCR, 8'h00);
    wr(QU_A_TCR, 8'h55);
    rd(QU_A_MSR, 8'h90, 8'hf0);
    wr(QU_A_MCR, 8'h42);
    rd(QU_A_MCR, 8'h42);
    wr(QU_A_TCR, 8'h13);
    rd(QU_A_TCR, 8'h13);
    wr(QU_A_TLR, 8'h20);
    level(7'h09, 7'h07);
    chk({14'h0000, rx_rdy, tx_rdy}, 16'h0002);
    wr(QU_A_TLR, 8'h01);
    level(7'h09, 7'h04);
    chk({14'h0000, rx_rdy, tx_rdy}, 16'h0003);
    wr(QU_A_MCR, 8'h04);
    rd(QU_A_FRDY, 8'ha5);
    wr(QU_A_MCR, 8'h54);
    rd(QU_A_TLR, 8'h01);
    wr(QU_A_MCR, 8'h02);
    rd(QU_A_MSR, 8'h00, 8'h00);
    level(7'h00, 7'h40);
    wr(QU_A_LCR, QU_LCR_EXT);
    wr(QU_A_ISR, 8'hf0);
    wr(QU_A_LCR, 8'h00);
    chk(16'(rts_b), 16'h0000);
    level(7'h0c, 7'h40);
    chk(16'(rts_b), 16'h0001);
    level(7'h08, 7'h40);
    chk(16'(rts_b), 16'h0001);
    level(7'h04, 7'h40);
    chk(16'(rts_b), 16'h0000);
    wr(QU_A_IER, 8'h80);
    rd(QU_A_ISR, 8'h00, 8'h00);
    lines(4'b0111);
    chk(16'(tx_halt), 16'h0001);
    rd(QU_A_ISR, 8'he0);
    rd(QU_A_ISR, 8'hc1);
    lines(4'b0110);
    chk(16'(tx_halt), 16'h0000);
    wr(QU_A_IER, 8'h20);
    for (int j = 0; j < 2; j++) begin
      rx_char = (j == 0) ? 8'h11 : 8'h13;
      rx_char_valid = 1'b1;
      cyc(1);
      rx_char_valid = 1'b0;
      cyc(2);
      rd(QU_A_ISR, (j == 0) ? 8'hc1 : 8'hd0);
    end
    rd(QU_A_ISR, 8'hc1);
    complete_run();
  end
endmodule
